// ### logic/ebsc_top.sv
// External bus strobe, fetch source and port control of the expansion interface
// Notes on behaviour
// - Address latch strobe pulses at oscillator/6 even with no external access.
// - Each external data access omits exactly one address latch strobe pulse.
// - Low address byte is valid at the latch strobe; outside logic latches it.
// - External code execution gives two fetch strobes per machine cycle.
// - A data access machine cycle suppresses both fetch strobes.
// - Fetch strobe stays inactive while executing internal code.
// - Source select high: internal code up to 0FFF, external above.
// - Source select low: all code external; romless systems tie it low.
// - First port multiplexes low address and data, driving ones strongly.
// - First port as general port floats pins whose latch holds one.
// - Third port drives high address byte for 16-bit accesses, strongly.
// - Second port pins with latch one are pulled up and readable.
// - Fourth port carries serial, interrupt, count and data strobe functions.
// - Setting the power-down bit opens the oscillator feedback element.
// - Clocking comes from the oscillator input; output pin left free externally.
// - In power-down both latch strobe and fetch strobe are held low.
// - Only hardware reset leaves power-down and restarts the oscillator.
`timescale 1ns/1ps
`default_nettype none
module ebsc_top
    import ebsc_pkg::*;
#(
    parameter int W = 8
) (
    input  wire logic         mclk,                 // Oscillator input clock
    input  wire logic         reset,
    input  wire logic         ce,
    input  wire logic         code_source_select,
    input  wire logic [15:0]  prog_counter,
    input  wire ebsc_xreq_t   xreq,
    input  wire logic         power_down_bit_set,
    input  wire logic         serial_tx,
    input  wire logic [W-1:0] p0_latch,
    input  wire logic [W-1:0] p1_latch,
    input  wire logic [W-1:0] p2_latch,
    input  wire logic [W-1:0] p3_latch,
    input  wire logic [W-1:0] p0_in,
    input  wire logic [W-1:0] p1_in,
    input  wire logic [W-1:0] p2_in,
    input  wire logic [W-1:0] p3_in,
    output logic              ale,
    output logic              program_fetch_strobe_n,
    output logic              osc_feedback_en,
    output logic              fetch_external,
    output logic [W-1:0]      rd_byte,
    output logic              rd_valid,
    output logic [W-1:0]      p0_out,
    output logic [W-1:0]      p0_oe_n,
    output logic [W-1:0]      p0_read,
    output logic [W-1:0]      p1_out,
    output logic [W-1:0]      p1_oe_n,
    output logic [W-1:0]      p1_pull,
    output logic [W-1:0]      p1_read,
    output logic [W-1:0]      p2_out,
    output logic [W-1:0]      p2_oe_n,
    output logic [W-1:0]      p2_pull,
    output logic [W-1:0]      p2_read,
    output logic [W-1:0]      p3_out,
    output logic [W-1:0]      p3_oe_n,
    output logic [W-1:0]      p3_pull,
    output ebsc_p3_alt_t      p3_alt
);
    // ==========================================================
    // Machine cycle state
    logic [3:0]  phase_q;
    logic        pd_q;
    logic        data_cyc_q;
    logic        fetch_ext_q;
    ebsc_xreq_t  xreq_q;
    logic [15:0] fetch_addr_q;
    logic [W-1:0] p3_read;

    // Phase decode
    wire logic run        = ce && !pd_q;
    wire logic ph_last    = (phase_q == PH_LAST);
    wire logic [3:0] phase_d = ph_last ? PH_RESET : 4'(phase_q + 4'h1);
    wire logic ale_win0   = (phase_q >= ALE0_FIRST) && (phase_q <= ALE0_LAST);
    wire logic ale_win1   = (phase_q >= ALE1_FIRST) && (phase_q <= ALE1_LAST);
    wire logic fetch_win  = ((phase_q >= FETCH0_FIRST) && (phase_q <= FETCH0_LAST)) ||
                            ((phase_q >= FETCH1_FIRST) && (phase_q <= FETCH1_LAST));
    wire logic xstb_win   = (phase_q >= XSTB_FIRST) && (phase_q <= XSTB_LAST);
    // Slot 0 address window alone serves a data cycle
    wire logic addr_slot0 = ale_win0 || (phase_q == PH_RESET);
    wire logic addr_win   = addr_slot0 || ale_win1 ||
                            (phase_q == 4'(ALE1_FIRST - 4'h1));

    // Code source: pin low forces external, high splits at the top address
    wire logic ext_code_d = !code_source_select ||
                            (prog_counter > INT_CODE_TOP);

    // Machine cycle of twelve oscillator periods, frozen in power-down
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            phase_q <= PH_RESET;
        end else if (run) begin
            phase_q <= phase_d;
        end
    end

    // Cycle kind is fixed for a whole machine cycle
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            data_cyc_q   <= 1'b0;
            fetch_ext_q  <= 1'b0;
            xreq_q       <= '0;
            fetch_addr_q <= '0;
        end else if (run && ph_last) begin
            data_cyc_q   <= xreq.ext_req;
            fetch_ext_q  <= ext_code_d;
            xreq_q       <= xreq;
            fetch_addr_q <= prog_counter;
        end
    end

    // Power-down latches until reset; no software path clears it
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pd_q <= 1'b0;
        end else if (ce && power_down_bit_set) begin
            pd_q <= 1'b1;
        end
    end

    // ==========================================================
    // Strobes
    // Slot 1 strobe is dropped in a data cycle, slot 0 latches the data address
    wire logic ale_d   = !pd_q && (ale_win0 || (ale_win1 && !data_cyc_q));
    wire logic fetch_d = !pd_q && fetch_ext_q && !data_cyc_q && fetch_win;
    wire logic wr_n_d  = !(data_cyc_q && xreq_q.write && xstb_win);
    wire logic rd_n_d  = !(data_cyc_q && !xreq_q.write && xstb_win);
    // Capture at the last period of each read window
    wire logic cap_code = fetch_d && ((phase_q == FETCH0_LAST) || (phase_q == FETCH1_LAST));
    wire logic cap_data = data_cyc_q && !xreq_q.write && (phase_q == XSTB_LAST);

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ale                    <= 1'b0;
            program_fetch_strobe_n <= 1'b1;
            osc_feedback_en        <= 1'b1;
            fetch_external         <= 1'b0;
        end else if (ce) begin
            ale                    <= ale_d;
            // Held low rather than idle high while powered down
            program_fetch_strobe_n <= pd_q ? 1'b0 : !fetch_d;
            osc_feedback_en        <= !pd_q;
            fetch_external         <= fetch_ext_q;
        end
    end

    // Read data from the multiplexed port; pins sampled directly
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rd_byte  <= '0;
            rd_valid <= 1'b0;
        end else if (ce) begin
            rd_valid <= run && (cap_code || cap_data);
            if (run && (cap_code || cap_data)) begin
                rd_byte <= p0_in;
            end
        end
    end

    // ==========================================================
    // Port steering
    // Low byte drives address around the strobe, then data or float for reads
    wire logic [15:0] bus_addr = data_cyc_q ? xreq_q.addr : fetch_addr_q;
    // Data cycles give the address once, so write data is not overrun in slot 1
    wire logic p0_addr_en  = (data_cyc_q ? addr_slot0 : (fetch_ext_q && addr_win)) && !pd_q;
    wire logic p0_data_en  = data_cyc_q && xreq_q.write && xstb_win && !pd_q;
    wire logic p0_bus_en   = p0_addr_en || p0_data_en;
    wire logic [W-1:0] p0_bus_val = p0_addr_en ? bus_addr[W-1:0] : xreq_q.wdata;
    // Code fetches are always 16-bit; data cycles say so themselves
    wire logic p2_bus_en   = !pd_q && (data_cyc_q ? xreq_q.addr16 : fetch_ext_q);
    // Fourth port alternates AND into the latch, as in a shared pin driver
    wire logic [W-1:0] p3_alt_mask = ~(W'(1) << P3_TXD | W'(1) << P3_WR | W'(1) << P3_RD);
    wire logic [W-1:0] p3_eff = p3_latch & (p3_alt_mask |
                                (W'(serial_tx) << P3_TXD) |
                                (W'(wr_n_d)    << P3_WR) |
                                (W'(rd_n_d)    << P3_RD));

    ebsc_qport #(.W(W), .OPEN_DRAIN(1'b1)) u_port0 (
        .mclk     (mclk),
        .reset    (reset),
        .ce       (ce),
        .latch    (p0_latch),
        .bus_en   (p0_bus_en),
        .bus_val  (p0_bus_val),
        .pin_in   (p0_in),
        .pin_out  (p0_out),
        .pin_oe_n (p0_oe_n),
        .pin_pull (),
        .pin_read (p0_read)
    );
    ebsc_qport #(.W(W), .OPEN_DRAIN(1'b0)) u_port1 (
        .mclk     (mclk),
        .reset    (reset),
        .ce       (ce),
        .latch    (p1_latch),
        .bus_en   (1'b0),
        .bus_val  ('0),
        .pin_in   (p1_in),
        .pin_out  (p1_out),
        .pin_oe_n (p1_oe_n),
        .pin_pull (p1_pull),
        .pin_read (p1_read)
    );
    ebsc_qport #(.W(W), .OPEN_DRAIN(1'b0)) u_port2 (
        .mclk     (mclk),
        .reset    (reset),
        .ce       (ce),
        .latch    (p2_latch),
        .bus_en   (p2_bus_en),
        .bus_val  (bus_addr[15:8]),
        .pin_in   (p2_in),
        .pin_out  (p2_out),
        .pin_oe_n (p2_oe_n),
        .pin_pull (p2_pull),
        .pin_read (p2_read)
    );
    ebsc_qport #(.W(W), .OPEN_DRAIN(1'b0)) u_port3 (
        .mclk     (mclk),
        .reset    (reset),
        .ce       (ce),
        .latch    (p3_eff),
        .bus_en   (1'b0),
        .bus_val  ('0),
        .pin_in   (p3_in),
        .pin_out  (p3_out),
        .pin_oe_n (p3_oe_n),
        .pin_pull (p3_pull),
        .pin_read (p3_read)
    );

    // Alternate inputs taken from registered pin reads
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            p3_alt <= '1;
        end else if (ce) begin
            p3_alt <= '{rxd: p3_read[P3_RXD], irq_zero: p3_read[P3_IRQ0],
                        irq_one: p3_read[P3_IRQ1], count_zero: p3_read[P3_CNT0],
                        count_one: p3_read[P3_CNT1]};
        end
    end

    // ==========================================================
    // Checks
    AST_ALE_RATE: assert property (@(posedge mclk) disable iff (reset)
        (run && phase_q == ALE0_FIRST) |=> ale ##1 ale ##1 !ale)
        else $error("latch strobe slot 0 missing");
    AST_ALE_SKIP: assert property (@(posedge mclk) disable iff (reset)
        (run && data_cyc_q && phase_q == ALE1_FIRST) |=> !ale[*2])
        else $error("latch strobe not skipped in data cycle");
    AST_P0_ADDR: assert property (@(posedge mclk) disable iff (reset)
        (run && ale_win0 && data_cyc_q) |=> (p0_oe_n == '0 && p0_out == xreq_q.addr[W-1:0]))
        else $error("low address not on port at strobe");
    AST_P0_WDATA: assert property (@(posedge mclk) disable iff (reset)
        (run && data_cyc_q && xreq_q.write && xstb_win)
        |=> (p0_oe_n == '0 && p0_out == xreq_q.wdata))
        else $error("write data not on port in strobe window");
    AST_FETCH_TWICE: assert property (@(posedge mclk) disable iff (reset)
        (run && fetch_ext_q && !data_cyc_q && phase_q == FETCH0_FIRST)
        |=> !program_fetch_strobe_n[*3] ##4 !program_fetch_strobe_n)
        else $error("fetch strobe count wrong");
    AST_FETCH_SKIP: assert property (@(posedge mclk) disable iff (reset)
        (ce && !pd_q && data_cyc_q) |=> program_fetch_strobe_n)
        else $error("fetch strobe in data cycle");
    AST_FETCH_INT: assert property (@(posedge mclk) disable iff (reset)
        (ce && !pd_q && !fetch_ext_q) |=> program_fetch_strobe_n)
        else $error("fetch strobe during internal code");
    AST_SRC_SEL: assert property (@(posedge mclk) disable iff (reset)
        (run && ph_last && code_source_select && prog_counter <= INT_CODE_TOP) |=> !fetch_ext_q)
        else $error("internal code range fetched externally");
    AST_PD_HOLD: assert property (@(posedge mclk) disable iff (reset)
        (ce && pd_q) |=> (!ale && !program_fetch_strobe_n && !osc_feedback_en))
        else $error("strobes not low in power-down");
    AST_PD_STICKY: assert property (@(posedge mclk) disable iff (reset)
        pd_q |=> pd_q && $stable(phase_q))
        else $error("power-down left without reset");
endmodule
`default_nettype wire

// ### include/ebsc_pkg.sv
// Shared constants and carriers for the external bus strobe control block
`default_nettype none
package ebsc_pkg;

    // ==========================================================
    // Timing
    localparam int          CLK_PERIOD_NS = 100;       // mclk period in ns
    localparam int          MC_OSC_PERIODS = 12;       // Oscillator periods per machine cycle
    localparam int          ALE_DIVIDE     = 6;        // Strobe rate is osc / 6
    localparam logic [3:0]  PH_LAST        = 4'(MC_OSC_PERIODS - 1);
    localparam logic [3:0]  PH_RESET       = 4'h0;

    // Strobe slot windows, in oscillator periods within a machine cycle
    localparam logic [3:0]  ALE0_FIRST     = 4'h1;
    localparam logic [3:0]  ALE0_LAST      = 4'h2;
    localparam logic [3:0]  ALE1_FIRST     = 4'(ALE0_FIRST + ALE_DIVIDE);
    localparam logic [3:0]  ALE1_LAST      = 4'(ALE0_LAST + ALE_DIVIDE);
    localparam logic [3:0]  FETCH0_FIRST   = 4'h3;
    localparam logic [3:0]  FETCH0_LAST    = 4'h5;
    localparam logic [3:0]  FETCH1_FIRST   = 4'(FETCH0_FIRST + ALE_DIVIDE);
    localparam logic [3:0]  FETCH1_LAST    = 4'(FETCH0_LAST + ALE_DIVIDE);
    localparam logic [3:0]  XSTB_FIRST     = 4'h4;
    localparam logic [3:0]  XSTB_LAST      = 4'ha;

    // ==========================================================
    // Address map and pin positions
    localparam logic [15:0] INT_CODE_TOP   = 16'h0fff; // Last internally held code address
    localparam int          P3_RXD         = 0;
    localparam int          P3_TXD         = 1;
    localparam int          P3_IRQ0        = 2;
    localparam int          P3_IRQ1        = 3;
    localparam int          P3_CNT0        = 4;
    localparam int          P3_CNT1        = 5;
    localparam int          P3_WR          = 6;
    localparam int          P3_RD          = 7;
    localparam logic [7:0]  LATCH_RESET    = 8'hff;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic        ext_req;   // Machine cycle is an external data access
        logic        write;     // 1 write, 0 read
        logic        addr16;    // 16-bit address, high byte on third port
        logic [15:0] addr;
        logic [7:0]  wdata;
    } ebsc_xreq_t;

    typedef struct packed {
        logic rxd;
        logic irq_zero;
        logic irq_one;
        logic count_zero;
        logic count_one;
    } ebsc_p3_alt_t;

endpackage
`default_nettype wire

// ### logic/ebsc_qport.sv
// One port: latch, bus override and pin driver with registered outputs
`timescale 1ns/1ps
`default_nettype none
module ebsc_qport
    import ebsc_pkg::*;
#(
    parameter int W          = 8,
    parameter bit OPEN_DRAIN = 1'b0
) (
    input  wire logic         mclk,
    input  wire logic         reset,
    input  wire logic         ce,
    input  wire logic [W-1:0] latch,
    input  wire logic         bus_en,
    input  wire logic [W-1:0] bus_val,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_out,
    output logic      [W-1:0] pin_oe_n,
    output logic      [W-1:0] pin_pull,
    output logic      [W-1:0] pin_read
);
    // ==========================================================
    // Drive selection
    // Bus mode drives both levels strongly; port mode only sinks
    wire logic [W-1:0] out_d  = bus_en ? bus_val : '0;
    wire logic [W-1:0] oe_n_d = bus_en ? '0 : latch;
    // Open-drain pins float on a one; the others keep a weak pull-up
    wire logic [W-1:0] pull_d = (OPEN_DRAIN || bus_en) ? '0 : latch;

    // ==========================================================
    // Output and input registers
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pin_out  <= '0;
            pin_oe_n <= '1;
            pin_pull <= OPEN_DRAIN ? '0 : '1;
            pin_read <= '1;
        end else if (ce) begin
            pin_out  <= out_d;
            pin_oe_n <= oe_n_d;
            pin_pull <= pull_d;
            pin_read <= pin_in;
        end
    end
endmodule
`default_nettype wire

// ### logic/unused_placeholder_none.sv
// Intentionally empty compile unit
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ### sim/ebsc_mem_model.sv
// External program and data memory with its low address latch
`timescale 1ns/1ps
`default_nettype none
module ebsc_mem_model (
    input  wire logic       mclk,
    input  wire logic       reset,
    input  wire logic       ale,
    input  wire logic       fetch_n,
    input  wire logic [7:0] p0_out,
    input  wire logic [7:0] p0_oe_n,
    input  wire logic [7:0] p2_pin,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    output logic      [7:0] p0_pin,
    output logic      [7:0] wr_byte
);
    logic [7:0] lo_q;
    logic [7:0] last_q;
    logic [7:0] mem_byte;
    logic       mem_en;
    // Code and data spaces differ only by the mixing constant
    assign mem_byte = lo_q ^ p2_pin ^ (fetch_n ? 8'ha5 : 8'h5a);
    assign mem_en   = ~fetch_n | ~rd_n;
    // Released bus shows the inverse of its last level, never a stale match
    assign p0_pin   = (~p0_oe_n & p0_out) | (p0_oe_n & (mem_en ? mem_byte : ~last_q));
    // Latch low address on the strobe, take write data while strobe is low
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            lo_q    <= 8'h00;
            last_q  <= 8'h00;
            wr_byte <= 8'h00;
        end else begin
            if (ale) lo_q <= p0_pin;
            if (!wr_n) wr_byte <= p0_pin;
            last_q <= p0_pin;
        end
    end
endmodule
`default_nettype wire

// ### sim/tb.sv
// Self-checking bench for the external bus strobe control block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ebsc_pkg::*;
    logic mclk, reset, ce, css, pd, serial_tx;
    logic [15:0] pc;
    ebsc_xreq_t xreq;
    logic [7:0] p0_latch, p1_latch, p2_latch, p3_latch, p1_ext, p3_ext;
    logic [7:0] p0_pin, p1_pin, p2_pin, p3_pin, rd_byte, wr_byte;
    logic [7:0] p0_out, p0_oe_n, p1_out, p1_oe_n, p1_pull, p1_read;
    logic [7:0] p2_out, p2_oe_n, p3_out, p3_oe_n, p0_read, p2_pull, p2_read, p3_pull;
    logic ale, fetch_n, osc_en, fetch_ext, rd_valid;
    ebsc_p3_alt_t p3_alt;
    int failures, n_tests, cyc, seed, ar, ff, k, nrv;
    logic [16:0] cases [6];
    // Pin levels: strong drive wins, otherwise pull-up or the outside driver
    assign p1_pin = (~p1_oe_n & p1_out) | (p1_oe_n & p1_ext);
    assign p2_pin = (~p2_oe_n & p2_out) | p2_oe_n;
    assign p3_pin = (~p3_oe_n & p3_out) | (p3_oe_n & {2'b11, p3_ext[5:0]});
    ebsc_top i_dut (
        .mclk(mclk), .reset(reset), .ce(ce), .code_source_select(css),
        .prog_counter(pc), .xreq(xreq), .power_down_bit_set(pd), .serial_tx(serial_tx),
        .p0_latch(p0_latch), .p1_latch(p1_latch), .p2_latch(p2_latch), .p3_latch(p3_latch),
        .p0_in(p0_pin), .p1_in(p1_pin), .p2_in(p2_pin), .p3_in(p3_pin),
        .ale(ale), .program_fetch_strobe_n(fetch_n), .osc_feedback_en(osc_en),
        .fetch_external(fetch_ext), .rd_byte(rd_byte), .rd_valid(rd_valid),
        .p0_out(p0_out), .p0_oe_n(p0_oe_n), .p0_read(p0_read), .p1_out(p1_out),
        .p1_oe_n(p1_oe_n), .p1_pull(p1_pull), .p1_read(p1_read), .p2_out(p2_out),
        .p2_oe_n(p2_oe_n), .p2_pull(p2_pull), .p2_read(p2_read), .p3_out(p3_out),
        .p3_oe_n(p3_oe_n), .p3_pull(p3_pull), .p3_alt(p3_alt)
    );
    ebsc_mem_model i_mem (
        .mclk(mclk), .reset(reset), .ale(ale), .fetch_n(fetch_n), .p0_out(p0_out),
        .p0_oe_n(p0_oe_n), .p2_pin(p2_pin), .rd_n(p3_pin[P3_RD]), .wr_n(p3_pin[P3_WR]),
        .p0_pin(p0_pin), .wr_byte(wr_byte)
    );
    // ==========================================================
    // Clock, timeout and helpers
    initial begin
        mclk = 1'b0;
        forever #(CLK_PERIOD_NS / 2) mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 2000) begin
            failures++;
            final_report();
        end
    end
    function automatic logic [7:0] mem_exp(input logic [15:0] a, input logic code);
        return a[7:0] ^ a[15:8] ^ (code ? 8'h5a : 8'ha5);
    endfunction
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Settle one machine cycle, then count strobe edges over two
    task automatic run(output int na, output int nf);
        logic pa, pf;
        repeat (12) @(negedge mclk);
        na = 0;
        nf = 0;
        nrv = 0;
        pa = ale;
        pf = fetch_n;
        repeat (24) begin
            @(negedge mclk);
            if (ale === 1'b1 && pa === 1'b0) na++;
            if (fetch_n === 1'b0 && pf === 1'b1) nf++;
            if (rd_valid === 1'b1) nrv++;
            pa = ale;
            pf = fetch_n;
        end
    endtask
    task automatic final_report();
        if (failures == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        seed = 54161;
        reset = 1'b1; ce = 1'b1; css = 1'b1; pd = 1'b0; serial_tx = 1'b1; pc = 16'h0000;
        xreq = '0; p0_latch = 8'hff; p1_latch = 8'hff; p2_latch = 8'hff; p3_latch = 8'hff;
        p1_ext = 8'h00; p3_ext = 8'hff;
        repeat (5) @(negedge mclk);
        reset = 1'b0;
        // Fetch source table: select and address; external expectation computed from them
        cases[0] = {1'b1, 16'h0fff}; cases[1] = {1'b1, 16'h1000}; cases[2] = {1'b0, 16'h0000};
        cases[3] = {1'b1, 16'($random(seed)) & 16'h0fff};
        cases[4] = {1'b1, 16'($random(seed)) | 16'h1000};
        cases[5] = {1'b0, 16'($random(seed))};
        for (k = 0; k < 6; k++) begin
            css = cases[k][16];
            pc = cases[k][15:0];
            p2_latch = 8'($random(seed));
            run(ar, ff);
            check("ale_rate", 16'(ar), 16'd4);
            check("fetch_ext", 16'(fetch_ext), 16'(!css || pc > INT_CODE_TOP));
            if (!css || pc > INT_CODE_TOP) begin
                check("fetch_count", 16'(ff), 16'd4);
                check("code_byte", 16'(rd_byte), 16'(mem_exp(pc, 1'b1)));
                check("code_valid", 16'(nrv), 16'd4);
            end else begin
                check("fetch_idle", 16'(ff), 16'd0);
                check("int_valid", 16'(nrv), 16'd0);
            end
        end
        // Back-to-back data reads and writes with external code
        css = 1'b0;
        for (k = 0; k < 4; k++) begin
            xreq = '{ext_req: 1'b1, write: k[0], addr16: !k[1], addr: 16'($random(seed)),
                     wdata: 8'($random(seed))};
            run(ar, ff);
            check("ale_skip", 16'(ar), 16'd2);
            check("fetch_skip", 16'(ff), 16'd0);
            check("p2_oe", 16'(p2_oe_n), xreq.addr16 ? 16'h0000 : 16'(p2_latch));
            if (k[0]) begin
                check("wr_byte", 16'(wr_byte), 16'(xreq.wdata));
                check("wr_valid", 16'(nrv), 16'd0);
            end else begin
                check("rd_byte", 16'(rd_byte),
                      16'(mem_exp({(xreq.addr16 ? xreq.addr[15:8] : p2_latch),
                                   xreq.addr[7:0]}, 1'b0)));
                check("rd_valid", 16'(nrv), 16'd2);
            end
        end
        xreq = '0;
        // General port modes and alternate inputs
        css = 1'b1; pc = 16'h0100;
        p0_latch = 8'($random(seed)); p1_latch = 8'($random(seed));
        p1_ext = 8'($random(seed));
        p3_ext = 8'($random(seed)) | 8'h02; serial_tx = 1'b0;
        run(ar, ff);
        check("p0_float", 16'(p0_oe_n), 16'(p0_latch));
        check("p0_read", 16'(p0_read & ~p0_latch), 16'h0000);
        check("p1_pull", 16'(p1_pull), 16'(p1_latch));
        check("p1_read", 16'(p1_read), 16'(p1_ext & p1_latch));
        check("p1_out", 16'(p1_out), 16'h0000);
        check("p2_pull", 16'(p2_pull), 16'(p2_latch));
        check("p2_read", 16'(p2_read), 16'(p2_latch));
        check("p3_pull", 16'(p3_pull), 16'h00fd);
        check("p3_alt", 16'(p3_alt),
              16'({p3_ext[0], p3_ext[2], p3_ext[3], p3_ext[4], p3_ext[5]}));
        check("p3_txd", 16'(p3_pin[P3_TXD]), 16'd0);
        serial_tx = 1'b1; p0_latch = 8'hff;
        // Clock enable low freezes the strobes
        ce = 1'b0;
        run(ar, ff);
        check("ce_hold", 16'(ar), 16'd0);
        ce = 1'b1;
        // Power-down, then only reset brings the strobes back
        pd = 1'b1;
        @(negedge mclk);
        pd = 1'b0;
        run(ar, ff);
        check("pd_osc", 16'(osc_en), 16'd0);
        check("pd_ale", 16'(ale), 16'd0);
        check("pd_fetch", 16'(fetch_n), 16'd0);
        check("pd_frozen", 16'(ar), 16'd0);
        reset = 1'b1;
        repeat (2) @(negedge mclk);
        reset = 1'b0;
        check("rst_osc", 16'(osc_en), 16'd1);
        run(ar, ff);
        check("rst_ale", 16'(ar), 16'd4);
        final_report();
    end
endmodule
`default_nettype wire
